// ==== hdl/eesr_pkg.sv ====
// eesr_pkg: shared constants for the serial eeprom read path, target and controller.
// assumes both ends run on the same 200 MHz system clock and share this package.
package eesr_pkg;

	// memory organisation
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;
	localparam int MEM_DEPTH = 128;
	localparam logic [6:0] PTR_RST = 7'h00;

	// address byte layout: fixed id nibble, three ignored bits, direction
	localparam logic [3:0] DEV_ID = 4'hA;
	localparam int ID_MSB = 7;
	localparam int ID_LSB = 4;
	localparam int DIR_POS = 0;
	localparam logic DIR_READ = 1'b1;
	localparam logic DIR_WRITE = 1'b0;

	// bit slots per byte: eight data slots then the acknowledge slot
	localparam logic [3:0] ACK_SLOT = 4'h8;
	localparam logic [3:0] LAST_BIT = 4'h7;

	// timing: the controller divides the system clock to make the serial clock
	localparam int CLK_PERIOD_NS = 5;
	localparam int SCL_PERIOD_NS = 2500;
	localparam int SCL_QTR_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);

	// read buffer depth in the controller
	localparam int RD_FIFO_DEPTH = 2;

	// true when an address byte carries our id nibble
	function automatic logic eesr_id_match(input logic [7:0] b);
		return b[ID_MSB:ID_LSB] == DEV_ID;
	endfunction : eesr_id_match

	// build an address byte; the three middle bits are sent as zero
	function automatic logic [7:0] eesr_addr_byte(input logic dir);
		return {DEV_ID, 3'h0, dir};
	endfunction : eesr_addr_byte

endpackage : eesr_pkg

// ==== hdl/eesr_if.sv ====
// eesr_if: two-wire link between the controller and the eeprom target.
// assumes open-drain data: a party pulls low when its enable is low and its data is low.
`timescale 1ns/1ps
interface eesr_if;
	logic scl;
	logic ctl_sda_o;
	logic ctl_sda_oe_n;
	logic tgt_sda_o;
	logic tgt_sda_oe_n;
	logic sda;

	// wired-and resolution of the data line, pulled high when nobody drives low
	assign sda = (ctl_sda_oe_n | ctl_sda_o) & (tgt_sda_oe_n | tgt_sda_o);

	modport ctrl (
		output scl,
		output ctl_sda_o,
		output ctl_sda_oe_n,
		input sda
	);

	modport target (
		input scl,
		input sda,
		output tgt_sda_o,
		output tgt_sda_oe_n
	);
endinterface : eesr_if

// ==== hdl/eesr_target.sv ====
// eesr_target: read side of a 128-byte serial eeprom target.
// assumes scl and sda arrive asynchronous to mclk_i and are oversampled many times per bit.
`timescale 1ns/1ps
module eesr_target #(
	parameter int ADDR_W = eesr_pkg::ADDR_W
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	// serial link
	eesr_if.target bus,
	// memory preload port
	input wire logic load_en_i,
	input wire logic [ADDR_W-1:0] load_addr_i,
	input wire logic [eesr_pkg::DATA_W-1:0] load_data_i,
	// status
	output logic busy_o,
	output logic [ADDR_W-1:0] ptr_o
);
	import eesr_pkg::*;

	// the pointer arithmetic relies on the width wrapping at the top location
	if (ADDR_W < 1 || ADDR_W > 8)
	begin : g_chk
		$error("eesr_target: ADDR_W must be 1 to 8");
	end

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DEV,
		ST_AACK,
		ST_TX,
		ST_MACK,
		ST_WADR,
		ST_WACK
	} eesr_tst_t;

	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
	logic scl_s1, scl_s2, scl_d;
	logic sda_s1, sda_s2, sda_d;
	eesr_tst_t st_reg, st_next;
	logic [3:0] bit_reg, bit_next;
	logic [7:0] sh_reg, sh_next;
	logic [ADDR_W-1:0] ptr_reg, ptr_next;
	logic oe_n_reg, oe_n_next;
	logic rw_reg, rw_next;
	logic mack_reg, mack_next;
	logic scl_rise, scl_fall, start_det, stop_det;
	logic [DATA_W-1:0] cur_byte;

	// preload only; the bus write path never reaches the array
	always_ff @(posedge mclk_i)
	begin
		if (load_en_i)
		begin
			mem[load_addr_i] <= load_data_i;
		end
	end

	// two-stage synchronisers, then one more stage for edge detection
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			scl_d <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			sda_d <= 1'b1;
		end
		else
		begin
			scl_s1 <= bus.scl;
			scl_s2 <= scl_s1;
			scl_d <= scl_s2;
			sda_s1 <= bus.sda;
			sda_s2 <= sda_s1;
			sda_d <= sda_s2;
		end
	end

	// line events; start and stop are data edges while the clock stays high
	assign scl_rise = scl_s2 & ~scl_d;
	assign scl_fall = ~scl_s2 & scl_d;
	assign start_det = scl_s2 & scl_d & sda_d & ~sda_s2;
	assign stop_det = scl_s2 & scl_d & ~sda_d & sda_s2;

	// byte at the counter, the one a current-address read returns
	assign cur_byte = mem[ptr_reg];

	// protocol engine; data only ever changes just after a falling clock edge
	always_comb
	begin
		st_next = st_reg;
		bit_next = bit_reg;
		sh_next = sh_reg;
		ptr_next = ptr_reg;
		oe_n_next = oe_n_reg;
		rw_next = rw_reg;
		mack_next = mack_reg;
		if (stop_det)
		begin
			st_next = ST_IDLE;
			oe_n_next = 1'b1;
		end
		else if (start_det)
		begin
			// a repeated start is taken from any state
			st_next = ST_DEV;
			bit_next = 4'h0;
			oe_n_next = 1'b1;
		end
		else
		begin
			case (st_reg)
				ST_IDLE:
				begin
					oe_n_next = 1'b1;
				end
				ST_DEV, ST_WADR:
				begin
					if (scl_rise && bit_reg != ACK_SLOT)
					begin
						sh_next = {sh_reg[6:0], sda_s2};
						bit_next = 4'(bit_reg + 4'h1);
					end
					if (scl_fall && bit_reg == ACK_SLOT)
					begin
						if (st_reg == ST_WADR)
						begin
							oe_n_next = 1'b0;
							st_next = ST_WACK;
						end
						else if (eesr_id_match(sh_reg))
						begin
							oe_n_next = 1'b0;
							rw_next = sh_reg[DIR_POS];
							st_next = ST_AACK;
						end
						else
						begin
							// another target was addressed: stay off the line
							st_next = ST_IDLE;
						end
					end
				end
				ST_AACK:
				begin
					if (scl_fall)
					begin
						bit_next = 4'h0;
						if (rw_reg == DIR_READ)
						begin
							sh_next = cur_byte;
							oe_n_next = cur_byte[7];
							ptr_next = ADDR_W'(ptr_reg + 1'b1);
							st_next = ST_TX;
						end
						else
						begin
							oe_n_next = 1'b1;
							st_next = ST_WADR;
						end
					end
				end
				ST_TX:
				begin
					if (scl_fall)
					begin
						if (bit_reg == LAST_BIT)
						begin
							// release so the controller can answer
							oe_n_next = 1'b1;
							st_next = ST_MACK;
						end
						else
						begin
							sh_next = {sh_reg[6:0], 1'b0};
							oe_n_next = sh_reg[6];
							bit_next = 4'(bit_reg + 4'h1);
						end
					end
				end
				ST_MACK:
				begin
					if (scl_rise)
					begin
						mack_next = ~sda_s2;
					end
					if (scl_fall)
					begin
						bit_next = 4'h0;
						if (mack_reg)
						begin
							sh_next = cur_byte;
							oe_n_next = cur_byte[7];
							ptr_next = ADDR_W'(ptr_reg + 1'b1);
							st_next = ST_TX;
						end
						else
						begin
							// line stays released until the stop
							st_next = ST_IDLE;
						end
					end
				end
				ST_WACK:
				begin
					if (scl_fall)
					begin
						// further write bytes go unanswered and nothing is programmed
						ptr_next = sh_reg[ADDR_W-1:0];
						oe_n_next = 1'b1;
						st_next = ST_IDLE;
					end
				end
				default:
				begin
					st_next = ST_IDLE;
					oe_n_next = 1'b1;
				end
			endcase
		end
	end

	// engine registers
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			st_reg <= ST_IDLE;
			bit_reg <= 4'h0;
			sh_reg <= 8'h00;
			ptr_reg <= ADDR_W'(PTR_RST);
			oe_n_reg <= 1'b1;
			rw_reg <= 1'b0;
			mack_reg <= 1'b0;
		end
		else
		begin
			st_reg <= st_next;
			bit_reg <= bit_next;
			sh_reg <= sh_next;
			ptr_reg <= ptr_next;
			oe_n_reg <= oe_n_next;
			rw_reg <= rw_next;
			mack_reg <= mack_next;
		end
	end

	// open drain: the data value is always low, the enable carries the bit
	assign bus.tgt_sda_o = 1'b0;
	assign bus.tgt_sda_oe_n = oe_n_reg;
	assign busy_o = st_reg != ST_IDLE;
	assign ptr_o = ptr_reg;

endmodule : eesr_target

// ==== hdl/eesr_ctrl.sv ====
// eesr_ctrl: two-wire controller issuing current-address and random reads.
// assumes it alone drives scl; read bytes leave through a two-entry buffer.
`timescale 1ns/1ps
module eesr_ctrl #(
	parameter int QTR_CYC = eesr_pkg::SCL_QTR_CYC,
	parameter int FIFO_DEPTH = eesr_pkg::RD_FIFO_DEPTH
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	// serial link
	eesr_if.ctrl bus,
	// command port
	input wire logic cmd_valid_i,
	output logic cmd_ready_o,
	input wire logic cmd_random_i,
	input wire logic [eesr_pkg::ADDR_W-1:0] cmd_addr_i,
	input wire logic [7:0] cmd_len_i,
	// read data stream
	output logic rd_valid_o,
	input wire logic rd_ready_i,
	output logic [eesr_pkg::DATA_W-1:0] rd_data_o,
	// status
	output logic done_o,
	output logic nack_o
);
	import eesr_pkg::*;

	// the target needs several samples per quarter to find the edges;
	// buffer pointers wrap by their width, so the depth must be a power of two
	if (QTR_CYC < 8 || QTR_CYC > 65535 || FIFO_DEPTH < 2 || FIFO_DEPTH > 16
		|| (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0)
	begin : g_chk
		$error("eesr_ctrl: QTR_CYC 8..65535 and FIFO_DEPTH power of two 2..16 required");
	end

	localparam int PW = $clog2(FIFO_DEPTH);

	typedef enum logic [2:0] {
		H_IDLE, H_START, H_DEVW, H_WADR, H_RSTART, H_DEVR, H_READ, H_STOP
	} eesr_hst_t;

	logic sda_s1, sda_s2;
	eesr_hst_t st_reg, st_next;
	logic [15:0] tmr_reg, tmr_next;
	logic [1:0] q_reg, q_next;
	logic [3:0] bit_reg, bit_next;
	logic [7:0] sh_reg, sh_next, left_reg, left_next;
	logic rnd_reg, rnd_next, ack_reg, ack_next;
	logic [ADDR_W-1:0] adr_reg, adr_next;
	logic scl_reg, scl_next, oe_n_reg, oe_n_next;
	logic done_reg, done_next, nack_reg, nack_next;
	logic tick, slot_end, stall, drv, push, pop;
	logic [DATA_W-1:0] fifo [0:FIFO_DEPTH-1];
	logic [PW-1:0] wp_reg, wp_next, rp_reg, rp_next;
	logic [PW:0] cnt_reg, cnt_next;

	// data line from the pin through two flops
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
		end
		else
		begin
			sda_s1 <= bus.sda;
			sda_s2 <= sda_s1;
		end
	end

	// a full buffer holds the clock low before the next read byte
	assign stall = st_reg == H_READ && bit_reg == 4'h0 && q_reg == 2'h0
		&& cnt_reg == (PW+1)'(FIFO_DEPTH);
	assign tick = tmr_reg == 16'(QTR_CYC - 1) && !stall;
	assign slot_end = tick && q_reg == 2'h3;
	assign push = st_reg == H_READ && slot_end && bit_reg == ACK_SLOT;
	assign pop = rd_valid_o && rd_ready_i;
	assign cmd_ready_o = st_reg == H_IDLE;

	// sequencer: each bit is one slot of four quarters
	always_comb
	begin
		st_next = st_reg;
		tmr_next = tick ? 16'h0000 : (stall ? tmr_reg : 16'(tmr_reg + 16'h1));
		q_next = tick ? 2'(q_reg + 2'h1) : q_reg;
		bit_next = bit_reg;
		sh_next = sh_reg;
		left_next = left_reg;
		rnd_next = rnd_reg;
		adr_next = adr_reg;
		ack_next = ack_reg;
		nack_next = nack_reg;
		done_next = 1'b0;
		if (st_reg == H_IDLE)
		begin
			tmr_next = 16'h0000;
			q_next = 2'h0;
			if (cmd_valid_i)
			begin
				rnd_next = cmd_random_i;
				adr_next = cmd_addr_i;
				left_next = (cmd_len_i == 8'h00) ? 8'h01 : cmd_len_i;
				nack_next = 1'b0;
				bit_next = 4'h0;
				st_next = H_START;
			end
		end
		else if (tick && q_reg == 2'h1)
		begin
			// sample in the middle of the high clock phase
			if (st_reg == H_READ && bit_reg != ACK_SLOT)
			begin
				sh_next = {sh_reg[6:0], sda_s2};
			end
			ack_next = ~sda_s2;
		end
		else if (slot_end)
		begin
			case (st_reg)
				H_START, H_RSTART:
				begin
					bit_next = 4'h0;
					if (st_reg == H_START && rnd_reg)
					begin
						sh_next = eesr_addr_byte(DIR_WRITE);
						st_next = H_DEVW;
					end
					else
					begin
						sh_next = eesr_addr_byte(DIR_READ);
						st_next = H_DEVR;
					end
				end
				H_DEVW, H_WADR, H_DEVR:
				begin
					if (bit_reg != ACK_SLOT)
					begin
						sh_next = {sh_reg[6:0], 1'b0};
						bit_next = 4'(bit_reg + 4'h1);
					end
					else if (!ack_reg)
					begin
						nack_next = 1'b1;
						st_next = H_STOP;
					end
					else
					begin
						bit_next = 4'h0;
						if (st_reg == H_DEVW)
						begin
							sh_next = 8'({1'b0, adr_reg});
							st_next = H_WADR;
						end
						else if (st_reg == H_WADR)
						begin
							st_next = H_RSTART;
						end
						else
						begin
							st_next = H_READ;
						end
					end
				end
				H_READ:
				begin
					if (bit_reg != ACK_SLOT)
					begin
						bit_next = 4'(bit_reg + 4'h1);
					end
					else
					begin
						bit_next = 4'h0;
						left_next = 8'(left_reg - 8'h01);
						if (left_reg == 8'h01)
						begin
							st_next = H_STOP;
						end
					end
				end
				H_STOP:
				begin
					done_next = 1'b1;
					st_next = H_IDLE;
				end
				default:
				begin
					st_next = H_IDLE;
				end
			endcase
		end
		// pins for the coming quarter, taken from the next state
		drv = 1'b1;
		if (st_next == H_DEVW || st_next == H_WADR || st_next == H_DEVR)
		begin
			drv = (bit_next == ACK_SLOT) ? 1'b1 : sh_next[7];
		end
		else if (st_next == H_READ && bit_next == ACK_SLOT)
		begin
			drv = left_next == 8'h01;
		end
		scl_next = q_next == 2'h1 || q_next == 2'h2;
		oe_n_next = drv;
		if (st_next == H_IDLE)
		begin
			scl_next = 1'b1;
			oe_n_next = 1'b1;
		end
		else if (st_next == H_START || st_next == H_RSTART)
		begin
			oe_n_next = q_next < 2'h2;
		end
		else if (st_next == H_STOP)
		begin
			// data rises while the clock is high: the stop
			scl_next = q_next != 2'h0;
			oe_n_next = q_next >= 2'h2;
		end
	end

	// buffer pointers; a push only happens with room checked at byte start
	always_comb
	begin
		wp_next = push ? PW'(wp_reg + 1'b1) : wp_reg;
		rp_next = pop ? PW'(rp_reg + 1'b1) : rp_reg;
		cnt_next = (PW+1)'(cnt_reg + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop});
	end

	always_ff @(posedge mclk_i)
	begin
		if (push)
		begin
			fifo[wp_reg] <= sh_reg;
		end
	end

	// sequencer and buffer registers
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			st_reg <= H_IDLE;
			tmr_reg <= 16'h0000;
			q_reg <= 2'h0;
			bit_reg <= 4'h0;
			sh_reg <= 8'h00;
			left_reg <= 8'h00;
			rnd_reg <= 1'b0;
			adr_reg <= '0;
			ack_reg <= 1'b0;
			scl_reg <= 1'b1;
			oe_n_reg <= 1'b1;
			done_reg <= 1'b0;
			nack_reg <= 1'b0;
			wp_reg <= '0;
			rp_reg <= '0;
			cnt_reg <= '0;
		end
		else
		begin
			st_reg <= st_next;
			tmr_reg <= tmr_next;
			q_reg <= q_next;
			bit_reg <= bit_next;
			sh_reg <= sh_next;
			left_reg <= left_next;
			rnd_reg <= rnd_next;
			adr_reg <= adr_next;
			ack_reg <= ack_next;
			scl_reg <= scl_next;
			oe_n_reg <= oe_n_next;
			done_reg <= done_next;
			nack_reg <= nack_next;
			wp_reg <= wp_next;
			rp_reg <= rp_next;
			cnt_reg <= cnt_next;
		end
	end

	assign bus.scl = scl_reg;
	assign bus.ctl_sda_o = 1'b0;
	assign bus.ctl_sda_oe_n = oe_n_reg;
	assign rd_valid_o = cnt_reg != '0;
	assign rd_data_o = fifo[rp_reg];
	assign done_o = done_reg;
	assign nack_o = nack_reg;

endmodule : eesr_ctrl

// ==== bench/eesr_chk.sv ====
// eesr_chk: timing and ownership checks on the two-wire link between both ends.
// assumes the ports are wired straight to the interface signals.
`timescale 1ns/1ps
module eesr_chk (
	// clock and reset
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	// link
	input wire logic scl,
	input wire logic sda,
	input wire logic ctl_sda_o,
	input wire logic ctl_sda_oe_n,
	input wire logic tgt_sda_o,
	input wire logic tgt_sda_oe_n
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (sys_rst_i);

	// start and stop: sda moves while scl stays high
	sequence start_s;
		scl && $past(scl) && $fell(sda);
	endsequence
	sequence stop_s;
		scl && $past(scl) && $rose(sda);
	endsequence

	// open drain: a party may only ever pull low
	od_value_a: assert property (!ctl_sda_o && !tgt_sda_o)
		else $error("driven sda value not low");
	// target starts pulling only while scl is low
	tgt_drive_a: assert property ($fell(tgt_sda_oe_n) |-> !scl)
		else $error("target pulled sda with scl high");
	// a target bit is held for at least eight clocks after the target starts pulling
	tgt_hold_a: assert property ($fell(tgt_sda_oe_n) |=> !tgt_sda_oe_n [*8])
		else $error("target bit released too early");
	// with scl high only the controller may move sda
	sda_stable_a: assert property (scl && $past(scl) && $changed(sda) |-> $changed(ctl_sda_oe_n))
		else $error("sda moved under high scl");
	// every start is made by the controller, never by the target
	start_own_a: assert property (start_s |-> !ctl_sda_oe_n && tgt_sda_oe_n)
		else $error("start not owned by controller");
	// after a stop the line is idle and released by both
	stop_idle_a: assert property (stop_s |=> (scl && tgt_sda_oe_n && ctl_sda_oe_n) [*6])
		else $error("link not idle after stop");
	// scl high phases last at least a quarter slot of the short bench setting, low phases at least six clocks
	scl_high_a: assert property ($rose(scl) |-> scl [*8])
		else $error("scl high phase too short");
	scl_low_a: assert property ($fell(scl) |-> !scl [*6])
		else $error("scl low phase too short");
endmodule : eesr_chk

// ==== bench/tb_eeprom_serial_read_ops.sv ====
// tb_eeprom_serial_read_ops: controller and target joined on one link, read streams
// compared with a bench copy of the memory; assumes design files compiled first.
`timescale 1ns/1ps
module tb_eeprom_serial_read_ops;
	import eesr_pkg::*;
	logic mclk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic load_en_i = 1'b0;
	logic [ADDR_W-1:0] load_addr_i = '0;
	logic [DATA_W-1:0] load_data_i = '0;
	logic cmd_valid_i = 1'b0;
	logic cmd_random_i = 1'b0;
	logic [ADDR_W-1:0] cmd_addr_i = '0;
	logic [7:0] cmd_len_i = 8'h01;
	logic rd_ready_i = 1'b0;
	logic busy_o, cmd_ready_o, rd_valid_o, done_o, nack_o;
	logic [ADDR_W-1:0] ptr_o;
	logic [DATA_W-1:0] rd_data_o;
	logic [DATA_W-1:0] mem_m [MEM_DEPTH];
	logic [DATA_W-1:0] got_q [$];
	logic [ADDR_W-1:0] ptr_m = '0;
	logic stall = 1'b0;
	int fail_count = 0;
	int num_checks = 0;

	// both ends on one link, short quarter slot to keep the run brief
	eesr_if lnk ();
	eesr_target i_eesr_target (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .bus(lnk),
		.load_en_i(load_en_i), .load_addr_i(load_addr_i), .load_data_i(load_data_i),
		.busy_o(busy_o), .ptr_o(ptr_o));
	eesr_ctrl #(.QTR_CYC(8)) i_eesr_ctrl (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .bus(lnk),
		.cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_random_i(cmd_random_i),
		.cmd_addr_i(cmd_addr_i), .cmd_len_i(cmd_len_i), .rd_valid_o(rd_valid_o),
		.rd_ready_i(rd_ready_i), .rd_data_o(rd_data_o), .done_o(done_o), .nack_o(nack_o));
	eesr_chk i_eesr_chk (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .scl(lnk.scl), .sda(lnk.sda),
		.ctl_sda_o(lnk.ctl_sda_o), .ctl_sda_oe_n(lnk.ctl_sda_oe_n),
		.tgt_sda_o(lnk.tgt_sda_o), .tgt_sda_oe_n(lnk.tgt_sda_oe_n));

	// 200 MHz system clock
	initial
	begin
		forever #2.5 mclk_i = ~mclk_i;
	end

	// sink pops at random, and not at all while stall is set, so the two-entry buffer fills and the link stalls
	always @(posedge mclk_i)
	begin
		if (rd_valid_o === 1'b1 && rd_ready_i === 1'b1)
			got_q.push_back(rd_data_o);
		rd_ready_i <= !stall && ($urandom % 3 != 0);
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask : check

	function automatic logic [DATA_W-1:0] exp_byte(input logic [ADDR_W-1:0] a);
		return mem_m[a];
	endfunction : exp_byte

	task automatic report_and_stop;
		$display("checks=%0d mismatches=%0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop

	// one read command, optionally with the sink stalled, then the stream compared
	task automatic rd_cmd(input logic rnd, input logic [ADDR_W-1:0] a, input int n,
		input logic stl);
		logic [ADDR_W-1:0] s;
		int k;
		s = rnd ? a : ptr_m;
		got_q.delete();
		stall <= stl;
		@(posedge mclk_i);
		cmd_valid_i <= 1'b1;
		cmd_random_i <= rnd;
		cmd_addr_i <= a;
		cmd_len_i <= n[7:0];
		// a zero length is served as a single byte
		if (n == 0)
			n = 1;
		k = 0;
		do
			@(posedge mclk_i);
		while (cmd_ready_o !== 1'b1 && ++k < 100);
		cmd_valid_i <= 1'b0;
		if (stl)
		begin
			// long enough to fill both entries; scl must then be parked low
			repeat (2500) @(posedge mclk_i);
			check(lnk.scl, 1'b0);
			check(rd_valid_o, 1'b1);
			check(busy_o, 1'b1);
			stall <= 1'b0;
		end
		k = 0;
		while (done_o !== 1'b1 && ++k < 20000)
			@(posedge mclk_i);
		check(done_o, 1'b1);
		k = 0;
		while (got_q.size() < n && ++k < 2000)
			@(posedge mclk_i);
		check(got_q.size(), n);
		check(got_q[0], exp_byte(s));
		for (int i = 1; i < n; i++)
			check(got_q[i], exp_byte(s + i[ADDR_W-1:0]));
		ptr_m = s + n[ADDR_W-1:0];
		check(ptr_o, ptr_m);
		check(nack_o, 1'b0);
		check(busy_o, 1'b0);
		$display("test done rnd=%0d addr=%0h len=%0d", rnd, s, n);
	endtask : rd_cmd

	initial
	begin
		logic [DATA_W-1:0] d;
		void'($urandom(25268));
		repeat (8) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		// memory has no reset, so fill every location through the load port
		for (int i = 0; i < MEM_DEPTH; i++)
		begin
			@(posedge mclk_i);
			d = 8'($urandom);
			mem_m[i] = d;
			load_en_i <= 1'b1;
			load_addr_i <= i[ADDR_W-1:0];
			load_data_i <= d;
		end
		@(posedge mclk_i);
		load_en_i <= 1'b0;
		check(ptr_o, 7'h00);
		check(lnk.scl, 1'b1);
		rd_cmd(1'b1, 7'h10, 1, 1'b0);
		rd_cmd(1'b0, 7'h00, 3, 1'b0);
		rd_cmd(1'b1, 7'h7E, 5, 1'b0);
		rd_cmd(1'b0, 7'h00, 5, 1'b1);
		rd_cmd(1'b1, 7'h7F, 1, 1'b0);
		rd_cmd(1'b0, 7'h00, 2, 1'b0);
		rd_cmd(1'b0, 7'h00, 0, 1'b0);
		// random mix of both read kinds, lengths and start addresses
		for (int t = 0; t < 10; t++)
			rd_cmd(1'($urandom), 7'($urandom), 1 + $urandom % 6, 1'b0);
		report_and_stop();
	end

	// watchdog sized above the expected run length
	initial
	begin
		repeat (100000) @(posedge mclk_i);
		fail_count++;
		report_and_stop();
	end
endmodule : tb_eeprom_serial_read_ops
